/* File: design/ims_pkg.sv */
package ims_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_MODE = 6'h01;
  localparam logic [5:0] ADDR_GAIN = 6'h02;
  localparam logic [5:0] ADDR_RATIO_LO = 6'h03;
  localparam logic [5:0] ADDR_RATIO_HI = 6'h04;
  localparam logic [5:0] ADDR_INPUT = 6'h05;
  // Mode register fields
  localparam int MODE_REAL = 0;
  localparam int MODE_CUSTOM = 1;
  localparam int MODE_POL = 2;
  localparam int MODE_STRETCH = 3;
  localparam int MODE_RAMP = 4;
  localparam int MODE_OVF_SO = 5;
  localparam int MODE_RSYNC_LO = 6;
  // Gain register fields
  localparam int GAIN_FINE_LO = 0;
  localparam int GAIN_COARSE_LO = 4;
  localparam int GAIN_AUTO_CLR = 6;
  localparam int GAIN_MSB_FLIP = 7;
  // Input mode field for scalar samples
  localparam int INPUT_REAL = 1;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h46;
  localparam logic [13:0] RST_RATIO = 14'h0007;
  localparam logic [7:0] RST_INPUT = 8'h00;
  localparam logic [15:0] RAMP_START = 16'h8000;
  // Timing and arithmetic counts
  localparam logic [14:0] N_MIN = 15'h0008;
  localparam logic [14:0] N_MAX = 15'h4000;
  localparam logic [5:0] SHIFT_BASE = 6'h03;
  localparam logic [5:0] COARSE_STEP = 6'h0c;
  localparam logic [15:0] REQ_WIDTH_DEF = 16'h0002;
  localparam logic [3:0] HOST_STROBE_CYC = 4'h6;
  localparam logic [3:0] HOST_GAP_CYC = 4'h2;
  localparam logic [14:0] COARSE0_MAX_N = 15'h0040;
  localparam logic [14:0] COARSE1_MAX_N = 15'h0400;
  // Sync select codes
  localparam logic [1:0] SYNC_NEVER = 2'h0;
  localparam logic [1:0] SYNC_PIN = 2'h1;
  localparam logic [1:0] SYNC_PULSE = 2'h2;
endpackage : ims_pkg

/* File: design/ims_link_if.sv */
`timescale 1ns/100ps
// Control bus, demand strobe and sync pins between the two ends
interface ims_link_if;
  logic ce_n;
  logic rd_n;
  logic wr_n;
  logic [5:0] addr;
  logic [7:0] c_host_out;
  logic c_host_oe;
  logic [7:0] c_dev_out;
  logic c_dev_oe;
  logic [7:0] c;
  logic req;
  logic sync_in_n;
  logic so_n;
  // Data bus level; idle bus floats high
  assign c = c_host_oe ? c_host_out : (c_dev_oe ? c_dev_out : 8'hff);
  modport device(input ce_n, input rd_n, input wr_n, input addr, input c, input sync_in_n,
                 output c_dev_out, output c_dev_oe, output req, output so_n);
  modport host(output ce_n, output rd_n, output wr_n, output addr, output c_host_out,
               output c_host_oe, output sync_in_n, input c, input req, input so_n);
endinterface : ims_link_if

/* File: design/ims_period_tick.sv */
`timescale 1ns/100ps
// Free running divider: one-cycle tick every period clocks
module ims_period_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [16:0] period,
  output logic tick
);
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // Compare against period-1 so a shrinking period cannot strand the count
  always_comb begin
    tick_d = 1'b0;
    if (restart) begin
      cnt_d = 17'h00000;
    end else if (cnt_q >= period - 17'h00001) begin
      cnt_d = 17'h00000;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : ims_period_tick

/* File: design/ims_device.sv */
`timescale 1ns/100ps
// Shared interpolation mode and gain control of the four-channel transmitter
module ims_device (
  input wire logic CLK,
  input wire logic RST_N,
  ims_link_if.device LINK,
  input wire logic CNT_TERMINAL_PULSE,
  input wire logic SINGLE_PULSE_SYNC,
  input wire logic USE_SINGLE_PULSE,
  input wire logic OUTPUT_SYNC,
  input wire logic OVERFLOW_ANY,
  input wire logic STATUS_BITS_LOW,
  input wire logic [3:0][15:0] SAMPLE_I,
  input wire logic [3:0][15:0] SAMPLE_Q,
  input wire logic [3:0][57:0] CIC_OUT,
  input wire logic [3:0] CIC_UNSTABLE,
  input wire logic [15:0] OUT_DATA,
  output logic SAMPLE_TAKE,
  output logic [3:0][15:0] CHAN_I,
  output logic [3:0][15:0] CHAN_Q,
  output logic [3:0][15:0] MIXER_IN,
  output logic [15:0] DAC_WORD,
  output logic [3:0] FLUSH,
  output logic REAL_MODE,
  output logic CUSTOM_COEFF,
  output logic CHECKSUM_LOAD,
  output logic [5:0] SHIFT_AMOUNT,
  output logic [14:0] INTERP_N
);
  // Two-bit sync selector decode
  function automatic logic sync_pick(input logic [1:0] sel, input logic pin, input logic pulse);
    if (sel == ims_pkg::SYNC_NEVER) begin
      return 1'b0;
    end else if (sel == ims_pkg::SYNC_PIN) begin
      return pin;
    end else if (sel == ims_pkg::SYNC_PULSE) begin
      return pulse;
    end else begin
      return 1'b1;
    end
  endfunction : sync_pick

  // Signed shift with round-half-up, result cut to sixteen bits
  function automatic logic [15:0] shift_round(input logic [57:0] x, input logic [5:0] sh);
    logic signed [58:0] t;
    t = $signed({x[57], x});
    t = t + (59'sh1 <<< (sh - 6'h01));
    t = t >>> sh;
    return t[15:0];
  endfunction : shift_round

  // Pin synchroniser: ce, rd, wr, addr, data, sync
  logic [17:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_ok_q;
  logic [17:0] pin_ok_d;
  logic [17:0] agree;
  logic bus_ce_n, bus_rd_n, bus_wr_n, sync_pin;
  logic [5:0] bus_addr;
  logic [7:0] bus_data;
  logic wr_act_q, wr_act_d;

  // A bit changes only once the second and third stages agree
  always_comb begin
    agree = ~(pin_s2_q ^ pin_s3_q);
    pin_ok_d = (pin_s3_q & agree) | (pin_ok_q & ~agree);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_q <= 18'h3ffff;
      pin_s2_q <= 18'h3ffff;
      pin_s3_q <= 18'h3ffff;
      pin_ok_q <= 18'h3ffff;
    end else begin
      pin_s1_q <= {LINK.ce_n, LINK.rd_n, LINK.wr_n, LINK.addr, LINK.c, LINK.sync_in_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_ok_q <= pin_ok_d;
    end
  end

  assign {bus_ce_n, bus_rd_n, bus_wr_n, bus_addr, bus_data} = pin_ok_q[17:1];
  assign sync_pin = ~pin_ok_q[0];

  // Register file; a write lands once per falling write strobe
  logic [7:0] mode_q, mode_d, gain_q, gain_d, input_q, input_d;
  logic [13:0] ratio_q, ratio_d;
  logic [7:0] rdata;
  logic c_oe_q, c_oe_d;
  logic [7:0] c_out_q;

  always_comb begin
    wr_act_d = ~bus_ce_n & ~bus_wr_n;
    mode_d = mode_q;
    gain_d = gain_q;
    ratio_d = ratio_q;
    input_d = input_q;
    if (wr_act_d && !wr_act_q) begin
      if (bus_addr == ims_pkg::ADDR_MODE) begin
        mode_d = bus_data;
      end else if (bus_addr == ims_pkg::ADDR_GAIN) begin
        gain_d = bus_data;
      end else if (bus_addr == ims_pkg::ADDR_RATIO_LO) begin
        ratio_d[7:0] = bus_data;
      end else if (bus_addr == ims_pkg::ADDR_RATIO_HI) begin
        ratio_d[13:8] = bus_data[5:0];
      end else if (bus_addr == ims_pkg::ADDR_INPUT) begin
        input_d = bus_data;
      end
    end
    if (bus_addr == ims_pkg::ADDR_MODE) begin
      rdata = mode_q;
    end else if (bus_addr == ims_pkg::ADDR_GAIN) begin
      rdata = gain_q;
    end else if (bus_addr == ims_pkg::ADDR_RATIO_LO) begin
      rdata = ratio_q[7:0];
    end else if (bus_addr == ims_pkg::ADDR_RATIO_HI) begin
      rdata = {2'h0, ratio_q[13:8]};
    end else if (bus_addr == ims_pkg::ADDR_INPUT) begin
      rdata = input_q;
    end else begin
      rdata = 8'h00;
    end
    c_oe_d = ~bus_ce_n & ~bus_rd_n;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_act_q <= 1'b0;
      mode_q <= ims_pkg::RST_MODE;
      gain_q <= ims_pkg::RST_GAIN;
      ratio_q <= ims_pkg::RST_RATIO;
      input_q <= ims_pkg::RST_INPUT;
      c_oe_q <= 1'b0;
      c_out_q <= 8'h00;
    end else begin
      wr_act_q <= wr_act_d;
      mode_q <= mode_d;
      gain_q <= gain_d;
      ratio_q <= ratio_d;
      input_q <= input_d;
      c_oe_q <= c_oe_d;
      c_out_q <= rdata;
    end
  end

  assign LINK.c_dev_out = c_out_q;
  assign LINK.c_dev_oe = c_oe_q;

  // Derived N and the three rate dividers
  logic [14:0] n_val, n_q;
  logic [16:0] n4, n2, take_period, req_period;
  logic take_tick, req_tick, ramp_tick, ramp_sync;

  always_comb begin
    n_val = {1'b0, ratio_q} + 15'h0001;
    if (n_val < ims_pkg::N_MIN) begin
      n_val = ims_pkg::N_MIN;
    end
    n4 = {n_val, 2'h0};
    n2 = {1'b0, n_val, 1'b0};
    take_period = mode_q[ims_pkg::MODE_REAL] ? n2 : n4;
    req_period = input_q[ims_pkg::INPUT_REAL] ? n2 : n4;
    ramp_sync = sync_pick(mode_q[ims_pkg::MODE_RSYNC_LO +: 2], sync_pin,
                          USE_SINGLE_PULSE ? SINGLE_PULSE_SYNC : CNT_TERMINAL_PULSE);
  end

  ims_period_tick u_take (.clk(CLK), .rst_n(RST_N), .restart(1'b0), .period(take_period),
                          .tick(take_tick));
  ims_period_tick u_req (.clk(CLK), .rst_n(RST_N), .restart(1'b0), .period(req_period),
                         .tick(req_tick));
  // Ramp paced at the complex input rate regardless of the real bit
  ims_period_tick u_ramp (.clk(CLK), .rst_n(RST_N), .restart(ramp_sync), .period(n4),
                          .tick(ramp_tick));

  // Demand strobe shaping
  logic req_on_q, req_on_d, req_pin_q, req_pin_d;
  logic [15:0] req_cnt_q, req_cnt_d, req_width;

  always_comb begin
    req_width = mode_q[ims_pkg::MODE_STRETCH] ? {2'h0, n_val[14:1]} : ims_pkg::REQ_WIDTH_DEF;
    req_on_d = req_on_q;
    req_cnt_d = req_cnt_q;
    if (req_tick) begin
      req_on_d = 1'b1;
      req_cnt_d = req_width - 16'h0001;
    end else if (req_on_q && req_cnt_q == 16'h0000) begin
      req_on_d = 1'b0;
    end else if (req_on_q) begin
      req_cnt_d = req_cnt_q - 16'h0001;
    end
    req_pin_d = req_on_d ^ mode_q[ims_pkg::MODE_POL];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_on_q <= 1'b0;
      req_cnt_q <= 16'h0000;
      req_pin_q <= 1'b0;
    end else begin
      req_on_q <= req_on_d;
      req_cnt_q <= req_cnt_d;
      req_pin_q <= req_pin_d;
    end
  end

  assign LINK.req = req_pin_q;

  // Sample path, ramp, gain and status outputs, all registered
  logic [15:0] ramp_q, ramp_d;
  logic [3:0][15:0] chi_q, chi_d, chq_q, chq_d, mix_q, mix_d;
  logic [15:0] dac_q, dac_d;
  logic [5:0] shift_q, shift_d;
  logic [3:0] flush_q, flush_d;
  logic take_q, ckl_q, so_n_q, so_n_d;

  // One shared setting set drives every channel alike
  always_comb begin
    ramp_d = ramp_q;
    if (ramp_sync) begin
      ramp_d = ims_pkg::RAMP_START;
    end else if (ramp_tick) begin
      ramp_d = ramp_q + 16'h0001;
    end
    shift_d = ims_pkg::SHIFT_BASE + {2'h0, gain_q[ims_pkg::GAIN_FINE_LO +: 4]}
            + 6'(ims_pkg::COARSE_STEP * {4'h0, gain_q[ims_pkg::GAIN_COARSE_LO +: 2]});
    chi_d = chi_q;
    chq_d = chq_q;
    for (int k = 0; k < 4; k++) begin
      if (take_tick) begin
        chi_d[k] = mode_q[ims_pkg::MODE_RAMP] ? ramp_q : SAMPLE_I[k];
        chq_d[k] = mode_q[ims_pkg::MODE_RAMP] ? ramp_q : SAMPLE_Q[k];
      end
      mix_d[k] = shift_round(CIC_OUT[k], shift_q);
    end
    flush_d = {4{gain_q[ims_pkg::GAIN_AUTO_CLR]}} & CIC_UNSTABLE;
    dac_d = {OUT_DATA[15] ^ gain_q[ims_pkg::GAIN_MSB_FLIP], OUT_DATA[14:0]};
    so_n_d = ~(OUTPUT_SYNC | (mode_q[ims_pkg::MODE_OVF_SO] & STATUS_BITS_LOW
             & OVERFLOW_ANY));
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ramp_q <= ims_pkg::RAMP_START;
      shift_q <= 6'h00;
      chi_q <= '0;
      chq_q <= '0;
      mix_q <= '0;
      flush_q <= 4'h0;
      dac_q <= 16'h0000;
      so_n_q <= 1'b1;
      take_q <= 1'b0;
      ckl_q <= 1'b0;
    end else begin
      ramp_q <= ramp_d;
      shift_q <= shift_d;
      chi_q <= chi_d;
      chq_q <= chq_d;
      mix_q <= mix_d;
      flush_q <= flush_d;
      dac_q <= dac_d;
      so_n_q <= so_n_d;
      take_q <= take_tick;
      ckl_q <= ramp_sync;
    end
  end

  // Mode outputs come straight from the register bits
  assign LINK.so_n = so_n_q;
  assign SAMPLE_TAKE = take_q;
  assign CHAN_I = chi_q;
  assign CHAN_Q = chq_q;
  assign MIXER_IN = mix_q;
  assign DAC_WORD = dac_q;
  assign FLUSH = flush_q;
  assign REAL_MODE = mode_q[ims_pkg::MODE_REAL];
  assign CUSTOM_COEFF = mode_q[ims_pkg::MODE_CUSTOM];
  assign CHECKSUM_LOAD = ckl_q;
  assign SHIFT_AMOUNT = shift_q;
  assign INTERP_N = n_q;

  // Registered copy of N for the status output
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      n_q <= ims_pkg::N_MIN;
    end else begin
      n_q <= n_val;
    end
  end
endmodule : ims_device

/* File: design/ims_host.sv */
`timescale 1ns/100ps
// Controlling end: drives the control bus and the sync pin
module ims_host (
  input wire logic CLK,
  input wire logic RST_N,
  ims_link_if.host LINK,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [5:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  input wire logic SYNC_PULSE,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic DEMAND_SEEN
);
  typedef enum {ST_IDLE, ST_HOLD, ST_STROBE, ST_GAP} ims_host_state_e;
  ims_host_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic wr_q, wr_d, ce_n_q, ce_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d;
  logic [5:0] addr_q, addr_d;
  logic [7:0] data_q, data_d, rsp_q, rsp_d, mode_q, mode_d;
  logic [13:0] ratio_q, ratio_d;
  logic [16:0] clr_q, clr_d;
  logic rv_q, rv_d, sync_n_q, req_q, seen_q;
  logic [14:0] n_val;
  logic [1:0] coarse;

  // Shadow of N and the coarse shift it needs
  always_comb begin
    n_val = {1'b0, ratio_q} + 15'h0001;
    // Same floor as the device, else the custom-bit hold runs short
    if (n_val < ims_pkg::N_MIN) begin
      n_val = ims_pkg::N_MIN;
    end
    if (n_val <= ims_pkg::COARSE0_MAX_N) begin
      coarse = 2'h0;
    end else if (n_val <= ims_pkg::COARSE1_MAX_N) begin
      coarse = 2'h1;
    end else begin
      coarse = 2'h2;
    end
  end

  // Bus cycle sequencer; strobes outlast the far end's pin filter
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    data_d = data_q;
    ce_n_d = ce_n_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    oe_d = oe_q;
    rsp_d = rsp_q;
    rv_d = 1'b0;
    mode_d = mode_q;
    ratio_d = ratio_q;
    clr_d = (mode_q[ims_pkg::MODE_CUSTOM] || clr_q[16]) ? clr_q : clr_q + 17'h00001;
    if (mode_q[ims_pkg::MODE_CUSTOM]) begin
      clr_d = 17'h00000;
    end
    case (st_q)
      ST_IDLE: begin
        if (CMD_VALID) begin
          wr_d = CMD_WRITE;
          addr_d = CMD_ADDR;
          data_d = CMD_WDATA;
          if (CMD_WRITE && CMD_ADDR == ims_pkg::ADDR_GAIN) begin
            data_d[ims_pkg::GAIN_COARSE_LO +: 2] = coarse;
          end
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Delay a setting of the custom bit until it has been clear 4N clocks
        if (!(wr_q && addr_q == ims_pkg::ADDR_MODE && data_q[ims_pkg::MODE_CUSTOM]
              && !mode_q[ims_pkg::MODE_CUSTOM] && clr_q < {n_val, 2'h0})) begin
          ce_n_d = 1'b0;
          rd_n_d = wr_q;
          wr_n_d = ~wr_q;
          oe_d = wr_q;
          cnt_d = ims_pkg::HOST_STROBE_CYC;
          st_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          ce_n_d = 1'b1;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          rsp_d = wr_q ? data_q : LINK.c;
          rv_d = 1'b1;
          if (wr_q && addr_q == ims_pkg::ADDR_MODE) begin
            mode_d = data_q;
            clr_d = 17'h00000;
          end else if (wr_q && addr_q == ims_pkg::ADDR_RATIO_LO) begin
            ratio_d[7:0] = data_q;
          end else if (wr_q && addr_q == ims_pkg::ADDR_RATIO_HI) begin
            ratio_d[13:8] = data_q[5:0];
          end
          cnt_d = ims_pkg::HOST_GAP_CYC;
          st_d = ST_GAP;
        end
      end
      default: begin
        oe_d = 1'b0;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      addr_q <= 6'h00;
      data_q <= 8'h00;
      ce_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      oe_q <= 1'b0;
      rsp_q <= 8'h00;
      rv_q <= 1'b0;
      mode_q <= ims_pkg::RST_MODE;
      ratio_q <= ims_pkg::RST_RATIO;
      clr_q <= 17'h00000;
      sync_n_q <= 1'b1;
      req_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      data_q <= data_d;
      ce_n_q <= ce_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      oe_q <= oe_d;
      rsp_q <= rsp_d;
      rv_q <= rv_d;
      mode_q <= mode_d;
      ratio_q <= ratio_d;
      clr_q <= clr_d;
      sync_n_q <= ~SYNC_PULSE;
      // Demand seen on its active edge, polarity from the shadow mode
      req_q <= LINK.req ^ mode_q[ims_pkg::MODE_POL];
      seen_q <= (LINK.req ^ mode_q[ims_pkg::MODE_POL]) & ~req_q;
    end
  end

  assign LINK.ce_n = ce_n_q;
  assign LINK.rd_n = rd_n_q;
  assign LINK.wr_n = wr_n_q;
  assign LINK.addr = addr_q;
  assign LINK.c_host_out = data_q;
  assign LINK.c_host_oe = oe_q;
  assign LINK.sync_in_n = sync_n_q;
  assign CMD_READY = (st_q == ST_IDLE);
  assign RSP_VALID = rv_q;
  assign RSP_DATA = rsp_q;
  assign DEMAND_SEEN = seen_q;
endmodule : ims_host

/* File: testbench/ims_link_asserts.sv */
`timescale 1ns/100ps
// Watches the link between the two ends: bus strobes and the demand strobe
module ims_link_asserts (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ce_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] c,
  input wire logic c_host_oe,
  input wire logic c_dev_oe,
  input wire logic req
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] sh_q [1:5];
  logic [7:0] sh_d [1:5];
  logic [17:0] quiet_q, quiet_d, per_q, per_d, len_q, len_d, per;
  logic act_q, act_d, act, rise, fall, ok;
  logic [14:0] n;
  // Strobe seen through polarity; N and period from the register shadow
  assign act = req ^ sh_q[1][2];
  assign rise = act && !act_q;
  assign fall = !act && act_q;
  assign n = ({sh_q[4][5:0], sh_q[3]} < 14'h0007) ? 15'h0008 :
             {1'b0, sh_q[4][5:0], sh_q[3]} + 15'h0001;
  assign per = sh_q[5][1] ? {2'h0, n, 1'b0} : {1'b0, n, 2'h0};
  // Device copy lags the bus, so only judge after a long quiet spell
  assign ok = quiet_q > {per[16:0], 1'b0};
  // Shadow of bus writes and strobe counters
  always_comb begin
    sh_d = sh_q;
    if (!ce_n && !wr_n && addr >= 6'h01 && addr <= 6'h05) sh_d[3'(addr)] = c;
    act_d = act;
    quiet_d = !ce_n ? 18'h0 : quiet_q + 18'(quiet_q != 18'h3ffff);
    per_d = rise ? 18'h1 : per_q + 18'(per_q != 18'h3ffff);
    len_d = act ? len_q + 18'h1 : 18'h0;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_q <= '{8'h00, 8'h46, 8'h07, 8'h00, 8'h00};
      act_q <= 1'b0;
      quiet_q <= 18'h0;
      per_q <= 18'h0;
      len_q <= 18'h0;
    end else begin
      sh_q <= sh_d;
      act_q <= act_d;
      quiet_q <= quiet_d;
      per_q <= per_d;
      len_q <= len_d;
    end
  end
  AST_REQ_WIDTH: assert property (ok && !sh_q[1][3] && rise |=> act ##1 !act)
    else $error("demand pulse not two cycles wide");
  AST_REQ_STRETCH: assert property (ok && sh_q[1][3] && fall |-> len_q == {4'h0, n[14:1]})
    else $error("stretched demand pulse not N/2 wide");
  AST_REQ_PERIOD: assert property (ok && rise |-> per_q == per)
    else $error("demand period wrong");
  AST_REQ_IDLE: assert property (ok && !sh_q[1][3] && !rise && per_q > 18'h4 |-> req == sh_q[1][2])
    else $error("demand idle level wrong");
  AST_STROBE_LEN: assert property ($fell(ce_n) |=> !ce_n [*5] ##1 ce_n) // Bus strobe
    else $error("bus strobe length wrong");
  AST_WR_HOLD: assert property (!wr_n && $past(!wr_n) |-> $stable(c) && $stable(addr) && c_host_oe)
    else $error("write data moved during strobe");
  AST_WR_NO_DEV: assert property (!wr_n |-> !c_dev_oe) // Bus ownership
    else $error("device drives during write");
  AST_OE_CAUSE: assert property ($rose(c_dev_oe) |-> !rd_n && !ce_n) // Bus ownership
    else $error("device drives without read");
  AST_NO_FIGHT: assert property (!(c_host_oe && c_dev_oe)) // Bus ownership
    else $error("both ends drive the bus");
  COV_STRETCH: cover property (ok && sh_q[1][3] && fall);
  COV_REAL_PERIOD: cover property (ok && sh_q[5][1] && rise);
  COV_READ: cover property ($rose(c_dev_oe));
endmodule : ims_link_asserts

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_top;
  logic CLK, RST_N, cmd_valid, cmd_write, sync_pulse, cnt_term, ovf, stat_low, out_sync;
  logic cmd_ready, rsp_valid, take, ck_load, real_mode, custom, a, b, dseen, os_pulse, use_os;
  logic [5:0] cmd_addr, es, shamt;
  logic [7:0] cmd_wdata, rsp_data, rd, g;
  logic [3:0][15:0] samp, samp_q, chan_i, chan_q, mix;
  logic [3:0][57:0] cic;
  logic [3:0] unst, flush;
  logic [15:0] out_data, dac, v, v2;
  logic [14:0] n_out;
  int num_errors, check_count, cyc, t, p, n, lowc, dn;
  int nt[4] = '{99, 16383, 1999, 7};
  ims_link_if link();
  ims_device u_ims_device (.CLK(CLK), .RST_N(RST_N), .LINK(link), .CNT_TERMINAL_PULSE(cnt_term),
    .SINGLE_PULSE_SYNC(os_pulse), .USE_SINGLE_PULSE(use_os), .OUTPUT_SYNC(out_sync),
    .OVERFLOW_ANY(ovf), .STATUS_BITS_LOW(stat_low), .SAMPLE_I(samp), .SAMPLE_Q(samp_q),
    .CIC_OUT(cic), .CIC_UNSTABLE(unst), .OUT_DATA(out_data), .SAMPLE_TAKE(take),
    .CHAN_I(chan_i), .CHAN_Q(chan_q), .MIXER_IN(mix), .DAC_WORD(dac), .FLUSH(flush),
    .REAL_MODE(real_mode), .CUSTOM_COEFF(custom), .CHECKSUM_LOAD(ck_load),
    .SHIFT_AMOUNT(shamt), .INTERP_N(n_out));
  ims_host u_ims_host (.CLK(CLK), .RST_N(RST_N), .LINK(link), .CMD_VALID(cmd_valid),
    .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .SYNC_PULSE(sync_pulse),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .DEMAND_SEEN(dseen));
  ims_link_asserts u_ims_link_asserts (.CLK(CLK), .RST_N(RST_N), .ce_n(link.ce_n),
    .rd_n(link.rd_n), .wr_n(link.wr_n), .addr(link.addr), .c(link.c),
    .c_host_oe(link.c_host_oe), .c_dev_oe(link.c_dev_oe), .req(link.req));
  // Expected mixer word: round half up, then keep the low 16 bits
  function automatic logic [15:0] rnd(logic [57:0] x, logic [5:0] s);
    logic signed [57:0] y;
    y = $signed(x) + (58'sh1 <<< (s - 6'h01));
    return 16'(y >>> s);
  endfunction : rnd
  task automatic bus(input logic w, input logic [5:0] ad, input logic [7:0] d);
    @(posedge CLK);
    while (cmd_ready !== 1'b1) @(posedge CLK);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= ad;
    cmd_wdata <= d;
    @(posedge CLK);
    cmd_valid <= 1'b0;
    t = 0;
    while (rsp_valid !== 1'b1 && t < 9000) begin
      @(posedge CLK);
      t++;
    end
    // A missing answer is a failure, not a silent pass
    if (t >= 9000) num_errors++;
    rd = rsp_data;
  endtask : bus
  task automatic gap();
    p = 0;
    while (take !== 1'b1 && p < 999) begin
      @(posedge CLK);
      p++;
    end
    p = 0;
    do begin
      @(posedge CLK);
      p++;
    end while (take !== 1'b1 && p < 999);
  endtask : gap
  task automatic step();
    v = chan_i[0];
    p = 0;
    while (chan_i[0] === v && p < 999) begin
      @(posedge CLK);
      p++;
    end
  endtask : step
  // Sync pulses held three cycles so the pin synchroniser cannot miss them
  // Source 0 sync pin, 1 terminal count, 2 one-shot
  task automatic fire(input int src, input int w, output logic seen);
    sync_pulse <= (src == 0);
    cnt_term <= (src == 1);
    os_pulse <= (src == 2);
    repeat (3) @(posedge CLK);
    sync_pulse <= 1'b0;
    cnt_term <= 1'b0;
    os_pulse <= 1'b0;
    seen = 1'b0;
    repeat (w) begin
      @(posedge CLK);
      seen |= (ck_load === 1'b1);
    end
  endtask : fire
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // Hang guard and custom-bit clear-time watch
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
    if (custom === 1'b1 && lowc > 0) `CHK("hold", 1'b1, lowc >= 32)
    lowc <= (custom === 1'b1) ? 0 : lowc + 1;
  end
  initial begin
    void'($urandom(32'h63db));
    {RST_N, cmd_valid, cmd_write, sync_pulse, cnt_term, ovf, stat_low, out_sync} = 8'h00;
    {os_pulse, use_os} = 2'h0;
    {cmd_addr, cmd_wdata, unst, out_data} = 34'h0;
    cic = '0;
    samp = {$urandom, $urandom};
    samp_q = {$urandom, $urandom};
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    bus(1'b0, 6'h01, 8'h00);
    `CHK("mode", 8'h00, rd)
    bus(1'b0, 6'h3f, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    foreach (nt[i]) begin
      bus(1'b1, 6'h03, 8'(nt[i]));
      bus(1'b1, 6'h04, 8'(nt[i] >> 8));
      g = 8'($urandom);
      bus(1'b1, 6'h02, g);
      n = nt[i] + 1;
      g[5:4] = n <= 64 ? 2'h0 : (n <= 1024 ? 2'h1 : 2'h2);
      es = 6'h03 + 6'(g[3:0]) + 6'h0c * 6'(g[5:4]);
      bus(1'b0, 6'h02, 8'h00);
      `CHK("gain", g, rd)
      `CHK("n", 15'(n), n_out)
      for (int k = 0; k < 4; k++) cic[k] <= 58'($signed(48'({$urandom, $urandom})));
      unst <= 4'($urandom);
      out_data <= 16'($urandom);
      repeat (3) @(posedge CLK);
      for (int k = 0; k < 4; k++) `CHK("mix", rnd(cic[k], es), mix[k])
      `CHK("shift", es, shamt)
      `CHK("dac", out_data ^ {g[7], 15'h0}, dac)
      `CHK("flush", unst & {4{g[6]}}, flush)
    end
    bus(1'b1, 6'h01, 8'h01);
    `CHK("real", 1'b1, real_mode)
    gap();
    `CHK("take2n", 16, p)
    samp_q <= '0;
    bus(1'b1, 6'h05, 8'h02);
    bus(1'b1, 6'h01, 8'h0c);
    `CHK("real", 1'b0, real_mode)
    gap();
    `CHK("take4n", 32, p)
    `CHK("chi", samp, chan_i)
    `CHK("chq", 64'h0, chan_q)
    dn = 0;
    repeat (64) begin
      @(posedge CLK);
      dn += (dseen === 1'b1);
    end
    `CHK("seen", 4, dn)
    repeat (200) @(posedge CLK);
    bus(1'b1, 6'h05, 8'h00);
    bus(1'b1, 6'h01, 8'h04);
    repeat (200) @(posedge CLK);
    bus(1'b1, 6'h01, 8'h02);
    `CHK("cust", 1'b1, custom)
    bus(1'b1, 6'h01, 8'h00);
    bus(1'b1, 6'h01, 8'h02);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 6'h01, {2'(k), 6'h10});
      fire(0, 16, a);
      fire(1, 8, b);
      `CHK("pin", k[0], a)
      `CHK("tc", k[1], b)
      if (k == 2) begin
        use_os <= 1'b1;
        fire(1, 8, a);
        fire(2, 8, b);
        use_os <= 1'b0;
        `CHK("os_tc", 1'b0, a)
        `CHK("os", 1'b1, b)
      end
      if (k == 0) begin
        step();
        step();
        `CHK("rper", 32, p)
        `CHK("rinc", v + 16'h0001, chan_i[0])
        `CHK("rall", {4{chan_i[0]}}, chan_i)
        `CHK("rallq", {4{chan_i[0]}}, chan_q)
      end
    end
    repeat (40) @(posedge CLK);
    `CHK("rsync", 16'h8000, chan_i[0])
    bus(1'b1, 6'h01, 8'h20);
    stat_low <= 1'b1;
    ovf <= 1'b1;
    repeat (3) @(posedge CLK);
    `CHK("so", 1'b0, link.so_n)
    stat_low <= 1'b0;
    repeat (3) @(posedge CLK);
    `CHK("so", 1'b1, link.so_n)
    final_report();
  end
endmodule : tb_top
